// [inc/spi_cs_master_regs.vh]
// register offsets, field positions, reset values and fixed settings of the clock-stop spi master
`ifndef SPI_CS_MASTER_REGS_VH
`define SPI_CS_MASTER_REGS_VH

// ----------------------------------------------------------------------
// register byte offsets (one 32-bit word each)
// ----------------------------------------------------------------------
`define OFS_CTRL            8'h00
`define OFS_STATUS          8'h04
`define OFS_TXDATA          8'h08
`define OFS_RXDATA          8'h0c

// ----------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------
`define CTRL_STOP_LSB       0
`define CTRL_STOP_MSB       1
`define CTRL_CPOL_BIT       2
`define CTRL_TXSP_BIT       3
`define CTRL_RXSP_BIT       4
`define CTRL_TXCS_BIT       5
`define CTRL_TXSS_BIT       6
`define CTRL_RXCS_BIT       7
`define CTRL_RXSS_BIT       8
`define CTRL_DIV_LSB        16
`define CTRL_DIV_MSB        23

// ----------------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------------
`define STAT_BUSY_BIT       0
`define STAT_TXFULL_BIT     1
`define STAT_RXVALID_BIT    2
`define STAT_OVERRUN_BIT    3

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_STOP            2'h0
`define RST_CPOL            1'h0
`define RST_DIV             8'h01

// ----------------------------------------------------------------------
// fixed master settings (read-only in the control register)
// ----------------------------------------------------------------------
`define FIX_TX_SYNC_POL     1'h1
`define FIX_RX_SYNC_POL     1'h1
`define FIX_TX_CLK_SRC      1'h1
`define FIX_TX_SYNC_SRC     1'h1
`define FIX_RX_CLK_SRC      1'h0
`define FIX_RX_SYNC_SRC     1'h0

`endif

// [design/word_buffer.v]
// two-entry word buffer with valid/ready on both sides
`timescale 1ns/1ps

module word_buffer #(
    parameter WIDTH = 8,
    parameter DEPTH = 2,
    parameter AW    = 1
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             in_valid_i,
    output wire             in_ready_o,
    input  wire [WIDTH-1:0] in_data_i,
    output wire             out_valid_o,
    input  wire             out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    // ------------------------------------------------------------------
    // storage and pointers
    // ------------------------------------------------------------------
    reg [WIDTH-1:0] mem_ff [0:DEPTH-1]; // word slots
    reg [AW-1:0]    wr_ptr_ff;          // next slot to fill
    reg [AW-1:0]    rd_ptr_ff;          // oldest slot
    reg [AW:0]      count_ff;           // words held

    wire push = in_valid_i & in_ready_o;
    wire pop  = out_valid_o & out_ready_i;

    // full and empty come straight from the count, so they never lie
    assign in_ready_o  = (count_ff != DEPTH[AW:0]);
    assign out_valid_o = (count_ff != {(AW+1){1'b0}});
    assign out_data_o  = mem_ff[rd_ptr_ff];

    // ------------------------------------------------------------------
    // pointer and count update
    // ------------------------------------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            wr_ptr_ff <= {AW{1'b0}};
            rd_ptr_ff <= {AW{1'b0}};
            count_ff  <= {(AW+1){1'b0}};
        end else begin
            // pointers wrap at the depth, not at a power of two
            if (push) begin
                wr_ptr_ff <= (wr_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
            end
            if (pop) begin
                rd_ptr_ff <= (rd_ptr_ff == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
            end
            if (push & ~pop) begin
                count_ff <= count_ff + 1'b1;
            end else if (pop & ~push) begin
                count_ff <= count_ff - 1'b1;
            end
        end
    end

    // data slots need no reset: a slot is only read once written
    always @(posedge clk_i) begin
        if (push) begin
            mem_ff[wr_ptr_ff] <= in_data_i;
        end
    end

endmodule

// [design/spi_cs_master.v]
// clock-stop spi master with wishbone register slave
//
// Decided for this implementation: the Wishbone slave port and the register offsets.
`timescale 1ns/1ps
`include "spi_cs_master_regs.vh"

// Behaviour
// (R1) serial clock period is (1+divide)*2 source cycles
// (R2) low phase per odd/zero or even divide
// (R3) high phase per odd/zero or even divide
// (R4) slave enable is inverted, active low
// (R5) tx clock/sync internal, rx sources external
// (R6) enable low before first clock edge
// (R7) stop 10b, pol 0: launch after rising
// (R8) stop 11b, pol 0: launch falling, early bit
// (R9) stop 10b, pol 1: launch falling, sample rising
// (R10) stop 11b, pol 1: sample falling, early bit
// (R11) data released on edge ending last bit
// (R12) stop 10b, pol 0: sample on falling
// (R13) idle clock at polarity, enable high
// (R14) slave shifts opposite edge while enabled
module spi_cs_master #(
    parameter WORD_BITS = 8
) (
    input  wire        REF_CLK_I,
    input  wire        SYS_RST_I,
    input  wire        WB_CYC_I,
    input  wire        WB_STB_I,
    input  wire        WB_WE_I,
    input  wire [7:0]  WB_ADR_I,
    input  wire [31:0] WB_DAT_I,
    input  wire [3:0]  WB_SEL_I,
    output reg  [31:0] WB_DAT_O,
    output reg         WB_ACK_O,
    output reg         SERIAL_CLOCK_OUT_O,
    output reg         SLAVE_ENABLE_OUT_N_O,
    output reg         SERIAL_DATA_OUT_O,
    output reg         SERIAL_DATA_OUT_OE_N_O,
    input  wire        SERIAL_DATA_IN_I
);

    // ------------------------------------------------------------------
    // constants and state codes
    // ------------------------------------------------------------------
    localparam [7:0] LAST_EDGE = 2 * WORD_BITS - 1;  // index of final edge
    localparam [2:0] ST_IDLE   = 3'h0;               // waiting for a word
    localparam [2:0] ST_SHIFT  = 3'h1;               // setup phase and edges
    localparam [2:0] ST_HOLD   = 3'h2;               // enable held after data
    localparam [2:0] ST_GAP    = 3'h3;               // enable high before next

    // length of one clock phase in source cycles, minus one
    function [8:0] phase_len;
        input [7:0] div;
        input       lvl_high;
        begin
            if (div == 8'h00 || div[0]) begin
                phase_len = {1'b0, div};                          // [R1] [R2] [R3]
            end else if (lvl_high) begin
                phase_len = {1'b0, div} + 9'h001;                 // [R3]
            end else begin
                phase_len = {1'b0, div} - 9'h001;                 // [R2]
            end
        end
    endfunction

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    reg [1:0]           stop_mode_ff;   // clock_stop_mode_field
    reg                 cpol_ff;        // tx_clock_polarity
    reg [7:0]           div_ff;         // clock_divide_value
    reg [WORD_BITS-1:0] rx_data_ff;     // last received word
    reg                 rx_valid_ff;    // unread word present
    reg                 overrun_ff;     // word lost to an unread one
    reg [2:0]           state_ff;       // transfer sequencer state
    reg [8:0]           cnt_ff;         // phase countdown
    reg [7:0]           edge_ff;        // edges done in this word
    reg                 early_ff;       // latched: first bit before first edge
    reg [7:0]           fdiv_ff;        // divide value latched per word
    reg [WORD_BITS-1:0] tx_shift_ff;    // outgoing bits, msb first
    reg [WORD_BITS-1:0] rx_shift_ff;    // incoming bits
    reg                 sdi_meta_ff;    // first synchroniser stage
    reg                 sdi_sync_ff;    // second synchroniser stage

    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    wire                 req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
    wire                 hit_ctl = (WB_ADR_I == `OFS_CTRL);
    wire                 hit_sta = (WB_ADR_I == `OFS_STATUS);
    wire                 hit_tx  = (WB_ADR_I == `OFS_TXDATA);
    wire                 hit_rx  = (WB_ADR_I == `OFS_RXDATA);
    wire                 tx_wr   = req & WB_WE_I & hit_tx & WB_SEL_I[0];
    wire                 buf_in_ready;
    wire                 buf_out_valid;
    wire [WORD_BITS-1:0] buf_out_data;
    // a full buffer holds off the ack, so the bus master stalls
    wire                 take    = req & (~tx_wr | buf_in_ready);
    wire                 rx_rd   = take & ~WB_WE_I & hit_rx;
    // a queued word counts as busy, so the one idle cycle between words never reads as done
    wire                 busy    = (state_ff != ST_IDLE) | buf_out_valid;
    // a new word is taken only with clock-stop enabled (field 1x)
    wire                 start   = (state_ff == ST_IDLE) & buf_out_valid & stop_mode_ff[1];

    // ------------------------------------------------------------------
    // transmit buffer
    // ------------------------------------------------------------------
    word_buffer #(
        .WIDTH (WORD_BITS),
        .DEPTH (2),
        .AW    (1)
    ) u_tx_buf (
        .clk_i       (REF_CLK_I),
        .rst_i       (SYS_RST_I),
        .in_valid_i  (tx_wr),
        .in_ready_o  (buf_in_ready),
        .in_data_i   (WB_DAT_I[WORD_BITS-1:0]),
        .out_valid_o (buf_out_valid),
        .out_ready_i (start),
        .out_data_o  (buf_out_data)
    );

    // ------------------------------------------------------------------
    // receive input synchroniser
    // ------------------------------------------------------------------
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            sdi_meta_ff <= 1'b0;
            sdi_sync_ff <= 1'b0;
        end else begin
            sdi_meta_ff <= SERIAL_DATA_IN_I;
            sdi_sync_ff <= sdi_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // wishbone slave: writes, ack and read data
    // ------------------------------------------------------------------
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            stop_mode_ff <= `RST_STOP;
            cpol_ff      <= `RST_CPOL;
            div_ff       <= `RST_DIV;
            WB_ACK_O     <= 1'b0;
            WB_DAT_O     <= 32'h0000_0000;
        end else begin
            // ack is a single pulse; it drops the cycle after it rose
            WB_ACK_O <= take;
            WB_DAT_O <= 32'h0000_0000;
            if (take & WB_WE_I & hit_ctl) begin
                if (WB_SEL_I[0]) begin
                    stop_mode_ff <= WB_DAT_I[`CTRL_STOP_MSB:`CTRL_STOP_LSB];
                    cpol_ff      <= WB_DAT_I[`CTRL_CPOL_BIT];
                end
                if (WB_SEL_I[2]) begin
                    div_ff <= WB_DAT_I[`CTRL_DIV_MSB:`CTRL_DIV_LSB];
                end
            end
            if (take & ~WB_WE_I) begin
                if (hit_ctl) begin
                    WB_DAT_O[`CTRL_STOP_MSB:`CTRL_STOP_LSB] <= stop_mode_ff;
                    WB_DAT_O[`CTRL_CPOL_BIT]                <= cpol_ff;
                    WB_DAT_O[`CTRL_TXSP_BIT]                <= `FIX_TX_SYNC_POL; // [R4]
                    WB_DAT_O[`CTRL_RXSP_BIT]                <= `FIX_RX_SYNC_POL; // [R4]
                    WB_DAT_O[`CTRL_TXCS_BIT]                <= `FIX_TX_CLK_SRC;  // [R5]
                    WB_DAT_O[`CTRL_TXSS_BIT]                <= `FIX_TX_SYNC_SRC; // [R5]
                    WB_DAT_O[`CTRL_RXCS_BIT]                <= `FIX_RX_CLK_SRC;  // [R5]
                    WB_DAT_O[`CTRL_RXSS_BIT]                <= `FIX_RX_SYNC_SRC; // [R5]
                    WB_DAT_O[`CTRL_DIV_MSB:`CTRL_DIV_LSB]   <= div_ff;
                end else if (hit_sta) begin
                    WB_DAT_O[`STAT_BUSY_BIT]    <= busy;
                    WB_DAT_O[`STAT_TXFULL_BIT]  <= ~buf_in_ready;
                    WB_DAT_O[`STAT_RXVALID_BIT] <= rx_valid_ff;
                    WB_DAT_O[`STAT_OVERRUN_BIT] <= overrun_ff;
                end else if (hit_rx) begin
                    WB_DAT_O[WORD_BITS-1:0] <= rx_data_ff;
                end
                // unmapped addresses answer with zero
            end
        end
    end

    // ------------------------------------------------------------------
    // transfer sequencer: clock divider, enable, shift and sample
    // ------------------------------------------------------------------
    wire last_edge = (edge_ff == LAST_EDGE);
    // in 11b the first bit leads, so odd edges launch; in 10b even ones do
    wire launch_e  = early_ff ? edge_ff[0] : ~edge_ff[0];
    wire [WORD_BITS-1:0] rx_word = {rx_shift_ff[WORD_BITS-2:0], sdi_sync_ff};
    wire word_done = (state_ff == ST_SHIFT) & (cnt_ff == 9'h000) & last_edge;

    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            state_ff               <= ST_IDLE;
            cnt_ff                 <= 9'h000;
            edge_ff                <= 8'h00;
            early_ff               <= 1'b0;
            fdiv_ff                <= `RST_DIV;
            tx_shift_ff            <= {WORD_BITS{1'b0}};
            rx_shift_ff            <= {WORD_BITS{1'b0}};
            SERIAL_CLOCK_OUT_O     <= `RST_CPOL;
            SLAVE_ENABLE_OUT_N_O   <= 1'b1;
            SERIAL_DATA_OUT_O      <= 1'b0;
            SERIAL_DATA_OUT_OE_N_O <= 1'b1;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    // clock parked at its idle level, slave deselected
                    SERIAL_CLOCK_OUT_O   <= cpol_ff;                      // [R13]
                    SLAVE_ENABLE_OUT_N_O <= 1'b1;                         // [R13]
                    if (start) begin
                        state_ff             <= ST_SHIFT;
                        edge_ff              <= 8'h00;
                        early_ff             <= stop_mode_ff[0];
                        fdiv_ff              <= div_ff;
                        // enable goes low a whole phase before the first edge
                        SLAVE_ENABLE_OUT_N_O <= 1'b0;                     // [R4] [R6]
                        cnt_ff               <= phase_len(div_ff, cpol_ff);
                        if (stop_mode_ff[0]) begin
                            // first bit leads the first edge by one idle phase
                            SERIAL_DATA_OUT_O      <= buf_out_data[WORD_BITS-1]; // [R8] [R10]
                            SERIAL_DATA_OUT_OE_N_O <= 1'b0;
                            tx_shift_ff            <= buf_out_data << 1;
                        end else begin
                            tx_shift_ff <= buf_out_data;
                        end
                    end
                end
                ST_SHIFT: begin
                    if (cnt_ff != 9'h000) begin
                        cnt_ff <= cnt_ff - 9'h001;
                    end else begin
                        // toggle the clock; next phase length follows its new level
                        SERIAL_CLOCK_OUT_O <= ~SERIAL_CLOCK_OUT_O;        // [R1]
                        cnt_ff             <= phase_len(fdiv_ff, ~SERIAL_CLOCK_OUT_O);
                        edge_ff            <= edge_ff + 8'h01;
                        if (launch_e & ~last_edge) begin
                            // [R7] [R8] [R9] launch on the leading or trailing edge
                            SERIAL_DATA_OUT_O      <= tx_shift_ff[WORD_BITS-1];
                            SERIAL_DATA_OUT_OE_N_O <= 1'b0;
                            tx_shift_ff            <= tx_shift_ff << 1;
                        end
                        if (~launch_e) begin
                            // [R8] [R9] [R10] [R12] [R14] sample on the other edge
                            rx_shift_ff <= rx_word;
                        end
                        if (last_edge) begin
                            // the edge that closes the last bit frees the line
                            SERIAL_DATA_OUT_OE_N_O <= 1'b1;               // [R11]
                            state_ff               <= ST_HOLD;
                            cnt_ff                 <= phase_len(fdiv_ff, cpol_ff);
                        end
                    end
                end
                ST_HOLD: begin
                    // one idle-level phase with the slave still enabled
                    if (cnt_ff != 9'h000) begin
                        cnt_ff <= cnt_ff - 9'h001;
                    end else begin
                        SLAVE_ENABLE_OUT_N_O <= 1'b1;                     // [R13]
                        state_ff             <= ST_GAP;
                        cnt_ff               <= phase_len(fdiv_ff, cpol_ff);
                    end
                end
                ST_GAP: begin
                    // keeps the deselect time at least one phase between words
                    if (cnt_ff != 9'h000) begin
                        cnt_ff <= cnt_ff - 9'h001;
                    end else begin
                        state_ff <= ST_IDLE;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------
    // receive flags: a completing word beats a clearing read or write
    // ------------------------------------------------------------------
    always @(posedge REF_CLK_I) begin
        if (SYS_RST_I) begin
            rx_data_ff  <= {WORD_BITS{1'b0}};
            rx_valid_ff <= 1'b0;
            overrun_ff  <= 1'b0;
        end else begin
            if (rx_rd) begin
                rx_valid_ff <= 1'b0;
            end
            if (take & WB_WE_I & hit_sta & WB_SEL_I[0] & WB_DAT_I[`STAT_OVERRUN_BIT]) begin
                overrun_ff <= 1'b0;
            end
            if (word_done) begin
                // in 11b the final edge launches, so the shifter already holds all bits
                rx_data_ff  <= launch_e ? rx_shift_ff : rx_word;       // [R8] [R10]
                rx_valid_ff <= 1'b1;
                // the old word is overwritten; the read in this cycle still saw it
                if (rx_valid_ff & ~rx_rd) begin
                    overrun_ff <= 1'b1;
                end
            end
        end
    end

endmodule

// [tb/spi_cs_master_sva.sv]
// checker: bus handshake and serial frame timing of the clock-stop spi master
`timescale 1ns/1ps
module spi_cs_master_sva #(
    parameter WORD_BITS = 8
) (
    input wire        REF_CLK_I,
    input wire        SYS_RST_I,
    input wire        WB_CYC_I,
    input wire        WB_STB_I,
    input wire        WB_WE_I,
    input wire [7:0]  WB_ADR_I,
    input wire [31:0] WB_DAT_I,
    input wire [3:0]  WB_SEL_I,
    input wire [31:0] WB_DAT_O,
    input wire        WB_ACK_O,
    input wire        SERIAL_CLOCK_OUT_O,
    input wire        SLAVE_ENABLE_OUT_N_O,
    input wire        SERIAL_DATA_OUT_OE_N_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    // ----------------------------------------------------------------------
    // helper logic: shadow of divide/polarity, phase and edge counters
    // ----------------------------------------------------------------------
    reg  [7:0] div_ff;   // snooped from control writes, frames never overlap a write
    reg        pol_ff;
    reg        clk_q_ff;
    reg        en_q_ff;
    reg  [9:0] ph_ff;    // cycles since last clock edge or enable fall
    reg  [5:0] edg_ff;   // clock edges inside the current frame
    wire       sc_chg = SERIAL_CLOCK_OUT_O != clk_q_ff;
    wire       en_fell = !SLAVE_ENABLE_OUT_N_O && en_q_ff;
    wire [9:0] lo_len = (div_ff == 8'h00 || div_ff[0]) ? div_ff + 10'h1 : {2'h0, div_ff};
    wire [9:0] hi_len = (div_ff == 8'h00 || div_ff[0]) ? div_ff + 10'h1 : div_ff + 10'h2;
    always @(posedge REF_CLK_I) begin
        clk_q_ff <= SERIAL_CLOCK_OUT_O;
        en_q_ff  <= SLAVE_ENABLE_OUT_N_O;
        ph_ff    <= (sc_chg || en_fell) ? 10'h1 : ph_ff + 10'h1;
        edg_ff   <= en_fell ? 6'h0 : edg_ff + {5'h0, sc_chg && !SLAVE_ENABLE_OUT_N_O};
        if (SYS_RST_I) begin
            div_ff <= 8'h01;
            pol_ff <= 1'b0;
        end else if (WB_CYC_I && WB_STB_I && WB_WE_I && WB_ADR_I == 8'h00) begin
            if (WB_SEL_I[2]) div_ff <= WB_DAT_I[23:16];
            if (WB_SEL_I[0]) pol_ff <= WB_DAT_I[2];
        end
    end
    sequence s_ack; WB_ACK_O ##1 !WB_ACK_O; endsequence
    property p_ack_pulse; WB_ACK_O |-> s_ack; endproperty
    property p_ack_cause; WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I); endproperty
    property p_ack_bound; WB_CYC_I && WB_STB_I && !WB_ACK_O |-> ##[1:400] WB_ACK_O; endproperty
    property p_dat_idle; !WB_ACK_O |-> WB_DAT_O == 32'h0; endproperty
    property p_phase; sc_chg && !SLAVE_ENABLE_OUT_N_O |-> ph_ff == (clk_q_ff ? hi_len : lo_len);
    endproperty
    property p_bits; $rose(SLAVE_ENABLE_OUT_N_O) |-> edg_ff == 2 * WORD_BITS; endproperty
    property p_lead; $fell(SLAVE_ENABLE_OUT_N_O) |-> $stable(SERIAL_CLOCK_OUT_O)
        && SERIAL_CLOCK_OUT_O == pol_ff; endproperty
    property p_oe_frame; !SERIAL_DATA_OUT_OE_N_O |-> !SLAVE_ENABLE_OUT_N_O; endproperty
    property p_release; $rose(SERIAL_DATA_OUT_OE_N_O) |-> sc_chg; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
    a_ack_bound: assert property (p_ack_bound) else $error("bus request never answered");
    a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
    a_phase: assert property (p_phase) else $error("clock phase length wrong");
    a_bits: assert property (p_bits) else $error("edge count per frame wrong");
    a_lead: assert property (p_lead) else $error("enable fell with clock moving");
    a_oe_frame: assert property (p_oe_frame) else $error("data driven outside frame");
    a_release: assert property (p_release) else $error("data release off edge");
endmodule
bind spi_cs_master spi_cs_master_sva #(.WORD_BITS(WORD_BITS)) u_sva (
    .REF_CLK_I(REF_CLK_I), .SYS_RST_I(SYS_RST_I), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
    .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I), .WB_DAT_I(WB_DAT_I), .WB_SEL_I(WB_SEL_I),
    .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SERIAL_CLOCK_OUT_O(SERIAL_CLOCK_OUT_O),
    .SLAVE_ENABLE_OUT_N_O(SLAVE_ENABLE_OUT_N_O),
    .SERIAL_DATA_OUT_OE_N_O(SERIAL_DATA_OUT_OE_N_O));

// [tb/spi_slave_model.sv]
// partner: spi slave that answers a fixed word and records what it receives
`timescale 1ns/1ps
module spi_slave_model (
    input  wire        clk_i,
    input  wire        sclk_i,
    input  wire        en_n_i,
    input  wire        mosi_i,
    input  wire [2:0]  mode_i,   // {polarity, stop field}
    input  wire [7:0]  word_i,
    output logic       miso_o,
    output logic [7:0] got_o
);
    logic [7:0] sh;
    logic       churn;
    int         cnt;
    initial begin
        sh = 8'h00;
        churn = 1'b0;
        cnt = 0;
        got_o = 8'h00;
    end
    // a deselected slave floats: churn so a stale bit is never mistaken for data
    always @(posedge clk_i) churn <= ~churn;
    assign miso_o = en_n_i ? churn : sh[7];
    always @(negedge en_n_i) begin
        sh = word_i;
        cnt = 0;
    end
    // sample where the master samples, shift on the opposite edge
    always @(sclk_i) if (!en_n_i) begin
        if (sclk_i == (mode_i[0] ^ mode_i[2])) begin
            got_o = {got_o[6:0], mosi_i};
        end else begin
            if (cnt > 0 || mode_i[0]) sh = sh << 1;
            cnt = cnt + 1;
        end
    end
endmodule

// [tb/test_spi_cs_master.sv]
// testbench: register access and serial transfers of the clock-stop spi master
`timescale 1ns/1ps
module test_spi_cs_master;
    reg         clk, rst, cyc, stb, we;
    reg  [7:0]  adr, sword, d, t;
    reg  [31:0] wdat, seed, rd;
    reg  [3:0]  sel;
    reg  [2:0]  mode;
    wire [31:0] rdat;
    wire [7:0]  got;
    wire        ack, sclk, en_n, mosi, oe_n, miso;
    integer     fail_count, num_checks, i;
    spi_cs_master u_spi_cs_master (.REF_CLK_I(clk), .SYS_RST_I(rst), .WB_CYC_I(cyc),
        .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_DAT_I(wdat), .WB_SEL_I(sel),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .SERIAL_CLOCK_OUT_O(sclk),
        .SLAVE_ENABLE_OUT_N_O(en_n), .SERIAL_DATA_OUT_O(mosi),
        .SERIAL_DATA_OUT_OE_N_O(oe_n), .SERIAL_DATA_IN_I(miso));
    spi_slave_model u_spi_slave_model (.clk_i(clk), .sclk_i(sclk), .en_n_i(en_n),
        .mosi_i(mosi), .mode_i(mode), .word_i(sword), .miso_o(miso), .got_o(got));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // expected control readback: fixed master bits 6..3 read one
    function [31:0] ctrl_val(input [2:0] m, input [7:0] dv);
        ctrl_val = {8'h00, dv, 8'h00, 1'b0, 4'hf, m};
    endfunction
    task tally_and_finish;
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task check(input string name, input [31:0] seen, input [31:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            fail_count = fail_count + 1;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // one classic cycle; request held until ack is sampled high
    task wb(input w, input [7:0] a, input [31:0] dat, input [3:0] s);
        integer n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= dat; sel <= s;
        n = 0;
        do begin @(posedge clk); n = n + 1; end while (ack !== 1'b1 && n < 1000);
        if (n >= 1000) begin fail_count = fail_count + 1; tally_and_finish; end
        rd = rdat;
        cyc <= 1'b0; stb <= 1'b0;
        @(posedge clk);
    endtask
    initial begin
        rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0;
        sel = 4'h0; seed = 32'h10cb; fail_count = 0; num_checks = 0; mode = 3'h0;
        sword = 8'h00;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        wb(1'b0, 8'h00, 32'h0, 4'hf);
        check("ctrl reset", rd, ctrl_val(3'h0, 8'h01));
        wb(1'b0, 8'h40, 32'h0, 4'hf);
        check("unmapped read", rd, 32'h0);
        wb(1'b1, 8'h08, 32'h5a, 4'hf);
        repeat (40) @(posedge clk);
        check("enable while stopped", {31'h0, en_n}, 32'h1);
        for (i = 0; i < 4; i = i + 1) begin
            seed = lfsr(seed);
            d = 8'h3 + seed[7:0] % 8'h6;
            sword = seed[15:8];
            t = seed[23:16];
            mode = {i[0], 1'b1, i[1]};
            wb(1'b1, 8'h00, ctrl_val(mode, d), 4'hf);
            wb(1'b0, 8'h00, 32'h0, 4'hf);
            check("ctrl", rd, ctrl_val(mode, d));
            repeat (3) wb(1'b1, 8'h08, {24'h0, t}, 4'h1);
            wb(1'b0, 8'h04, 32'h0, 4'hf);
            check("tx full", {31'h0, rd[1]}, 32'h1);
            wb(1'b1, 8'h08, {24'h0, t}, 4'h1);
            repeat (200) if (rd[3:0] !== 4'hc) wb(1'b0, 8'h04, 32'h0, 4'hf);
            check("status done", rd, 32'hc);
            check("idle clock", {30'h0, sclk, en_n}, {30'h0, mode[2], 1'b1});
            check("mosi word", {24'h0, got}, {24'h0, t});
            wb(1'b0, 8'h0c, 32'h0, 4'hf);
            check("miso word", rd, {24'h0, sword});
            wb(1'b0, 8'h04, 32'h0, 4'hf);
            check("overrun", rd, 32'h8);
            wb(1'b1, 8'h04, 32'h8, 4'h1);
            wb(1'b0, 8'h04, 32'h0, 4'hf);
            check("overrun clear", rd, 32'h0);
        end
        tally_and_finish;
    end
endmodule
